// >>> src/caw_params.svh
`ifndef CAW_PARAMS_SVH
`define CAW_PARAMS_SVH

// Register byte addresses on the APB.
`define CAW_ADDR_CONTROL      12'h000
`define CAW_ADDR_MODE         12'h004
`define CAW_ADDR_COUNT_LOW    12'h008
`define CAW_ADDR_COUNT_HIGH   12'h00C
`define CAW_ADDR_MOD5_MODE    12'h010
`define CAW_ADDR_MOD5_LOW     12'h014
`define CAW_ADDR_MOD5_HIGH    12'h018
`define CAW_ADDR_IRQ_EN       12'h01C

// Counter control register fields.
`define CAW_CTL_RUN_BIT       6
`define CAW_CTL_MATCH5_BIT    5

// Counter mode register fields.
`define CAW_MD_IDLE_BIT       7
`define CAW_MD_WDE_BIT        6
`define CAW_MD_LOCK_BIT       5
`define CAW_MD_CPS_HI         3
`define CAW_MD_CPS_LO         1

// Module mode register fields.
`define CAW_CPM_ECOM_BIT      6
`define CAW_CPM_MAT_BIT       3

// Reset values.
`define CAW_RST_CPS           3'h0
`define CAW_RST_BYTE          8'h00
`define CAW_RST_CPM           8'h00

// Clock selections.
`define CAW_CPS_DIV12         3'h0
`define CAW_CPS_DIV4          3'h1
`define CAW_CPS_SYSTEM_CLOCK        3'h4
`define CAW_DIV12_COUNT       4'hC
`define CAW_DIV4_COUNT        4'h4

`endif

// >>> src/caw_pkg.sv
package caw_pkg;

    // APB request from the master.
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } caw_apb_req_s;

    // APB answer to the master.
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } caw_apb_rsp_s;

    // Counter clock sources.
    typedef enum logic [2:0] {
        CAW_SRC_DIV12  = 3'h0,
        CAW_SRC_DIV4   = 3'h1,
        CAW_SRC_SYSTEM_CLOCK = 3'h4
    } caw_src_e;

endpackage

// >>> src/caw_watchdog.sv
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "caw_params.svh"

// Notes on behaviour
// RL1 - Watchdog enable turns module five into watchdog
// RL2 - Watchdog comes up enabled after reset
// RL3 - Counter forced on, counter writes ignored
// RL4 - Clock select and idle bit frozen
// RL5 - Module five forced compare, mode writes blocked
// RL6 - Run writes ineffective; run reads software value
// RL7 - Reset on low overflow during high match
// RL8 - High compare write loads counter plus offset
// RL9 - Timeout is offset overflows plus remainder
// RL10 - Writing match flag one forces reset
// RL11 - Enable or lock bit enables watchdog
// RL12 - Lock holds until reset; enable clear disables
// RL13 - Reset defaults divide twelve, zero bytes
// RL14 - Idle bit suspends counting during idle
// RL15 - Software disables, configures, enables, then updates
// RL16 - Compare match sets flag, requests interrupt
// RL17 - Match flag stays until software clears
// RL18 - Compare and match enables select timer mode
// RL19 - Low write clears compare enable; high sets
// RL20 - Capture input held two cycles minimum
// RL21 - Low byte wrap carries into high byte
// RL22 - Watchdog reset is one-cycle request
module caw_watchdog
    import caw_pkg::*;
(
    // Clock and reset.
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave.
    input  wire caw_pkg::caw_apb_req_s apb_req,
    output caw_pkg::caw_apb_rsp_s      apb_rsp,
    // System side.
    input  wire logic                  cpu_idle,
    output logic                       wdt_reset_req,
    output logic                       match_irq
);
    import caw_pkg::*;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic       run_r;
    logic       match5_r;
    logic       idle_r;
    logic       wde_r;
    logic       lock_r;
    logic [2:0] cps_r;
    logic [7:0] cnt_lo_r;
    logic [7:0] cnt_hi_r;
    logic [7:0] cpm5_r;
    logic [7:0] cpl5_r;
    logic [7:0] cph5_r;
    logic       irq_en_r;
    logic [3:0] div_r;
    logic       rst_req_r;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    logic        wr;
    logic [7:0]  wb;
    logic        wdt_on;
    logic        tick;
    logic        run_eff;
    logic        lo_wrap;
    logic [15:0] count;
    logic [7:0]  cpm5_eff;
    logic        timer_mode;
    logic        cmp_hit;
    logic        force_rst;
    logic        wdt_fire;

    assign wr      = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign wb      = apb_req.pwdata[7:0];
    // Either bit holds the watchdog on.
    assign wdt_on  = wde_r || lock_r; // [RL11] [RL1]
    // Counter runs when forced by the watchdog or by software, unless idle suspends it.
    assign run_eff = (run_r || wdt_on) && !(idle_r && cpu_idle); // [RL3] [RL14]
    assign lo_wrap = tick && run_eff && (cnt_lo_r == 8'hFF);
    assign count   = {cnt_hi_r, cnt_lo_r};

    // Module five is seen in compare mode while the watchdog owns it.
    always_comb
    begin
        cpm5_eff = cpm5_r;
        if (wdt_on)
        begin
            cpm5_eff[`CAW_CPM_ECOM_BIT] = 1'b1; // [RL5]
            cpm5_eff[`CAW_CPM_MAT_BIT]  = 1'b1;
        end
    end

    assign timer_mode = cpm5_eff[`CAW_CPM_ECOM_BIT] && cpm5_eff[`CAW_CPM_MAT_BIT]; // [RL18]
    assign cmp_hit    = timer_mode && !wdt_on && tick && run_eff && (count == {cph5_r, cpl5_r}); // [RL16]
    assign force_rst  = wdt_on && wr && (apb_req.paddr == `CAW_ADDR_CONTROL) && wb[`CAW_CTL_MATCH5_BIT]; // [RL10]
    // Overflow of the low byte while the high byte matches expires the watchdog.
    assign wdt_fire   = wdt_on && lo_wrap && (cnt_hi_r == cph5_r); // [RL7] [RL9]

    // ----------------------------------------------------------------
    // Counter clock divider
    // ----------------------------------------------------------------

    // Produces the counter tick enable from the selected source.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_r <= 4'h0;
        else if (cps_r == `CAW_CPS_SYSTEM_CLOCK)
            div_r <= 4'h0;
        else if (tick)
            div_r <= 4'h0;
        else
            div_r <= div_r + 4'h1;
    end

    always_comb
    begin
        case (cps_r)
            `CAW_CPS_SYSTEM_CLOCK: tick = 1'b1;
            `CAW_CPS_DIV4:   tick = (div_r == (`CAW_DIV4_COUNT - 4'h1));
            default:         tick = (div_r == (`CAW_DIV12_COUNT - 4'h1)); // [RL13]
        endcase
    end

    // ----------------------------------------------------------------
    // Control and mode registers
    // ----------------------------------------------------------------

    // Mode register: enable, lock, clock select and idle bit.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wde_r  <= 1'b1; // [RL2]
            lock_r <= 1'b0;
            idle_r <= 1'b0;
            cps_r  <= `CAW_RST_CPS; // [RL13]
        end
        else if (wr && apb_req.paddr == `CAW_ADDR_MODE)
        begin
            // Lock is sticky; with lock clear, clearing enable disables.
            wde_r  <= wb[`CAW_MD_WDE_BIT]; // [RL12]
            lock_r <= lock_r || wb[`CAW_MD_LOCK_BIT]; // [RL12]
            if (!wdt_on)
            begin
                idle_r <= wb[`CAW_MD_IDLE_BIT]; // [RL4]
                cps_r  <= wb[`CAW_MD_CPS_HI:`CAW_MD_CPS_LO];
            end
        end
    end

    // Run bit is stored as written; the watchdog forces counting regardless.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run_r <= 1'b0;
        else if (wr && apb_req.paddr == `CAW_ADDR_CONTROL)
            run_r <= wb[`CAW_CTL_RUN_BIT]; // [RL6]
    end

    // Match flag: hardware set wins over a software clear.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            match5_r <= 1'b0;
        else if (cmp_hit)
            match5_r <= 1'b1; // [RL16] [RL17]
        else if (wr && apb_req.paddr == `CAW_ADDR_CONTROL && !wdt_on)
            match5_r <= wb[`CAW_CTL_MATCH5_BIT];
    end

    // Interrupt enable for the module match.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_en_r <= 1'b0;
        else if (wr && apb_req.paddr == `CAW_ADDR_IRQ_EN)
            irq_en_r <= wb[0];
    end

    // Module five mode register, blocked while the watchdog runs.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cpm5_r <= `CAW_RST_CPM;
        else if (wr && apb_req.paddr == `CAW_ADDR_MOD5_MODE && !wdt_on)
            cpm5_r <= wb; // [RL5]
        else if (wr && apb_req.paddr == `CAW_ADDR_MOD5_LOW && !wdt_on)
            cpm5_r[`CAW_CPM_ECOM_BIT] <= 1'b0; // [RL19]
        else if (wr && apb_req.paddr == `CAW_ADDR_MOD5_HIGH && !wdt_on)
            cpm5_r[`CAW_CPM_ECOM_BIT] <= 1'b1; // [RL19]
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------

    // Sixteen-bit counter; software writes only while the watchdog is off.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_lo_r <= `CAW_RST_BYTE; // [RL13]
            cnt_hi_r <= `CAW_RST_BYTE;
        end
        else if (wr && !wdt_on && apb_req.paddr == `CAW_ADDR_COUNT_LOW)
            cnt_lo_r <= wb; // [RL3]
        else if (wr && !wdt_on && apb_req.paddr == `CAW_ADDR_COUNT_HIGH)
            cnt_hi_r <= wb; // [RL3]
        else if (tick && run_eff)
        begin
            cnt_lo_r <= cnt_lo_r + 8'h01;
            if (lo_wrap)
                cnt_hi_r <= cnt_hi_r + 8'h01; // [RL21]
        end
    end

    // ----------------------------------------------------------------
    // Module five compare bytes
    // ----------------------------------------------------------------

    // Low byte is the offset; a high write in watchdog mode reloads the deadline.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpl5_r <= `CAW_RST_BYTE; // [RL13]
            cph5_r <= `CAW_RST_BYTE;
        end
        else if (wr && apb_req.paddr == `CAW_ADDR_MOD5_LOW)
            cpl5_r <= wb;
        else if (wr && apb_req.paddr == `CAW_ADDR_MOD5_HIGH)
        begin
            if (wdt_on)
                cph5_r <= cnt_hi_r + cpl5_r; // [RL8] [RL9]
            else
                cph5_r <= wb;
        end
    end

    // ----------------------------------------------------------------
    // Watchdog reset request
    // ----------------------------------------------------------------

    // One-cycle pulse to the system reset logic.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rst_req_r <= 1'b0;
        else
            rst_req_r <= (wdt_fire || force_rst) && !rst_req_r; // [RL22] [RL7] [RL10]
    end

    assign wdt_reset_req = rst_req_r;
    assign match_irq     = match5_r && irq_en_r; // [RL16]

    // ----------------------------------------------------------------
    // APB read path
    // ----------------------------------------------------------------

    // Zero-wait slave; unmapped addresses read zero with an error.
    always_comb
    begin
        apb_rsp         = '0;
        apb_rsp.pready  = 1'b1;
        case (apb_req.paddr)
            `CAW_ADDR_CONTROL:
            begin
                apb_rsp.prdata[`CAW_CTL_RUN_BIT]    = run_r; // [RL6]
                apb_rsp.prdata[`CAW_CTL_MATCH5_BIT] = match5_r;
            end
            `CAW_ADDR_MODE:
            begin
                apb_rsp.prdata[`CAW_MD_IDLE_BIT]                  = idle_r;
                apb_rsp.prdata[`CAW_MD_WDE_BIT]                   = wde_r;
                apb_rsp.prdata[`CAW_MD_LOCK_BIT]                  = lock_r;
                apb_rsp.prdata[`CAW_MD_CPS_HI:`CAW_MD_CPS_LO]     = cps_r;
            end
            `CAW_ADDR_COUNT_LOW:  apb_rsp.prdata[7:0] = cnt_lo_r;
            `CAW_ADDR_COUNT_HIGH: apb_rsp.prdata[7:0] = cnt_hi_r;
            `CAW_ADDR_MOD5_MODE:  apb_rsp.prdata[7:0] = cpm5_eff;
            `CAW_ADDR_MOD5_LOW:   apb_rsp.prdata[7:0] = cpl5_r;
            `CAW_ADDR_MOD5_HIGH:  apb_rsp.prdata[7:0] = cph5_r;
            `CAW_ADDR_IRQ_EN:     apb_rsp.prdata[0]   = irq_en_r;
            default:              apb_rsp.pslverr     = apb_req.psel && apb_req.penable;
        endcase
    end

endmodule // caw_watchdog

// >>> sim/caw_watchdog_assertions.sv
`timescale 1ns/1ps
`include "caw_params.svh"

module caw_watchdog_assertions
    import caw_pkg::*;
(
    // Clock and reset.
    input wire logic                  pclk,
    input wire logic                  presetn,
    // Bus and system side.
    input wire caw_pkg::caw_apb_req_s apb_req,
    input wire caw_pkg::caw_apb_rsp_s apb_rsp,
    input wire logic                  cpu_idle,
    input wire logic                  wdt_reset_req,
    input wire logic                  match_irq
);
    logic        en_r;
    logic        lock_r;
    logic        idle_r;
    logic        run_r;
    logic [2:0]  cps_r;
    logic [11:0] a;
    logic        wr;
    logic        rd;
    logic        on;

    // Decode the access phase.
    assign a  = apb_req.paddr;
    assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
    assign on = en_r | lock_r;

    // Mode bits as software should see them.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_r   <= 1'b1;
            lock_r <= 1'b0;
            idle_r <= 1'b0;
            cps_r  <= `CAW_RST_CPS;
        end
        else if (wr && a == `CAW_ADDR_MODE)
        begin
            en_r   <= apb_req.pwdata[6];
            lock_r <= lock_r | apb_req.pwdata[5];
            if (!on)
            begin
                idle_r <= apb_req.pwdata[7];
                cps_r  <= apb_req.pwdata[3:1];
            end
        end
    end

    // Run bit as software last wrote it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run_r <= 1'b0;
        else if (wr && a == `CAW_ADDR_CONTROL)
            run_r <= apb_req.pwdata[6];
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A forcing write to the match flag while guarding.
    sequence s_force;
        wr && a == `CAW_ADDR_CONTROL && apb_req.pwdata[5] && on;
    endsequence

    AST_RST_PULSE: assert property (wdt_reset_req |=> !wdt_reset_req)
        else $error("reset request longer than one cycle");
    AST_FORCE: assert property (s_force |-> ##[1:2] wdt_reset_req)
        else $error("forced reset missing");
    AST_EN_READ: assert property (rd && a == `CAW_ADDR_MODE |-> apb_rsp.prdata[6] == en_r)
        else $error("enable bit wrong");
    AST_LOCK: assert property (rd && a == `CAW_ADDR_MODE |-> apb_rsp.prdata[5] == lock_r)
        else $error("lock bit wrong");
    AST_FROZEN: assert property (rd && a == `CAW_ADDR_MODE |-> {apb_rsp.prdata[7], apb_rsp.prdata[3:1]} == {idle_r, cps_r})
        else $error("clock select or idle bit wrong");
    AST_MOD5: assert property (rd && a == `CAW_ADDR_MOD5_MODE && on |-> apb_rsp.prdata[6] && apb_rsp.prdata[3])
        else $error("module five not forced");
    AST_RUN: assert property (rd && a == `CAW_ADDR_CONTROL |-> apb_rsp.prdata[6] == run_r)
        else $error("run bit wrong");
    AST_FLAG: assert property (match_irq && !(wr && (a == `CAW_ADDR_CONTROL || a == `CAW_ADDR_IRQ_EN)) |=> match_irq)
        else $error("match flag dropped");
endmodule // caw_watchdog_assertions

bind caw_watchdog caw_watchdog_assertions i_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .cpu_idle(cpu_idle), .wdt_reset_req(wdt_reset_req), .match_irq(match_irq));

// >>> sim/tb_caw_watchdog.sv
`timescale 1ns/1ps
`include "caw_params.svh"

module tb_caw_watchdog;
    import caw_pkg::*;
    logic         pclk;
    logic         presetn;
    caw_apb_req_s req;
    caw_apb_rsp_s rsp;
    logic         cpu_idle;
    logic         wdt_reset_req;
    logic         match_irq;
    logic [31:0]  rdata;
    logic         serr;
    int           err_count = 0;
    int           checks_done = 0;
    int           cyc = 0;
    int           t0 = 0;

    caw_watchdog i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
                        .cpu_idle(cpu_idle), .wdt_reset_req(wdt_reset_req), .match_irq(match_irq));

    // 25 MHz clock.
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Cycle count, which also cuts a hung run short.
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d, errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; read data is taken at the edge that sees pready.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        req.psel   <= 1'b1;
        req.pwrite <= w;
        req.paddr  <= a;
        req.pwdata <= {24'h000000, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (rsp.pready !== 1'b1)
            @(posedge pclk);
        rdata = rsp.prdata;
        serr  = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 8'h00);
        check(rdata, exp);
    endtask

    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t0 = cyc;
    endtask

    task automatic wait_rst();
        while (wdt_reset_req !== 1'b1)
            @(posedge pclk);
    endtask

    // Untouched defaults expire after 256 slow ticks.
    task automatic t_timeout();
        do_reset();
        wait_rst();
        check(cyc - t0 >= 3060 && cyc - t0 <= 3090, 1'b1);
        @(posedge pclk);
        check(wdt_reset_req, 1'b0);
    endtask

    task automatic t_defaults();
        do_reset();
        rd(`CAW_ADDR_MODE, 32'h40);
        rd(`CAW_ADDR_MOD5_LOW, 32'h0);
        rd(`CAW_ADDR_MOD5_MODE, 32'h48);
        rd(`CAW_ADDR_CONTROL, 32'h0);
        xfer(1'b0, 12'h040, 8'h00);
        check(serr, 1'b1);
    endtask

    // Guarded writes are ignored, then a forced reset.
    task automatic t_frozen();
        wr(`CAW_ADDR_MODE, 8'hC2);
        rd(`CAW_ADDR_MODE, 32'h40);
        wr(`CAW_ADDR_COUNT_HIGH, 8'h55);
        rd(`CAW_ADDR_COUNT_HIGH, 32'h0);
        wr(`CAW_ADDR_MOD5_MODE, 8'h00);
        rd(`CAW_ADDR_MOD5_MODE, 32'h48);
        wr(`CAW_ADDR_CONTROL, 8'h20);
        repeat (3) if (wdt_reset_req !== 1'b1) @(posedge pclk);
        check(wdt_reset_req, 1'b1);
    endtask

    // Configure in the advised order, then time the update.
    task automatic t_update();
        do_reset();
        wr(`CAW_ADDR_MODE, 8'h00);
        wr(`CAW_ADDR_MODE, 8'h08);
        rd(`CAW_ADDR_MODE, 32'h08);
        wr(`CAW_ADDR_COUNT_LOW, 8'h00);
        wr(`CAW_ADDR_COUNT_HIGH, 8'h00);
        wr(`CAW_ADDR_MOD5_LOW, 8'h02);
        wr(`CAW_ADDR_MODE, 8'h48);
        wr(`CAW_ADDR_MOD5_HIGH, 8'hA5);
        t0 = cyc;
        rd(`CAW_ADDR_MOD5_HIGH, 32'h02);
        wait_rst();
        check(cyc - t0 >= 745 && cyc - t0 <= 775, 1'b1);
    endtask

    task automatic t_lock();
        do_reset();
        wr(`CAW_ADDR_MODE, 8'h20);
        rd(`CAW_ADDR_MODE, 32'h20);
        wr(`CAW_ADDR_MODE, 8'h00);
        rd(`CAW_ADDR_MODE, 32'h20);
        rd(`CAW_ADDR_MOD5_MODE, 32'h48);
    endtask

    // Compare mode with the guard off.
    task automatic t_swtimer();
        do_reset();
        wr(`CAW_ADDR_MODE, 8'h00);
        rd(`CAW_ADDR_MOD5_MODE, 32'h0);
        wr(`CAW_ADDR_MOD5_MODE, 8'h48);
        wr(`CAW_ADDR_MOD5_LOW, 8'h10);
        rd(`CAW_ADDR_MOD5_MODE, 32'h08);
        wr(`CAW_ADDR_MOD5_HIGH, 8'h00);
        rd(`CAW_ADDR_MOD5_MODE, 32'h48);
        wr(`CAW_ADDR_COUNT_LOW, 8'h00);
        wr(`CAW_ADDR_COUNT_HIGH, 8'h00);
        wr(`CAW_ADDR_IRQ_EN, 8'h01);
        wr(`CAW_ADDR_CONTROL, 8'h40);
        while (match_irq !== 1'b1)
            @(posedge pclk);
        rd(`CAW_ADDR_CONTROL, 32'h60);
        repeat (20) @(posedge pclk);
        check(match_irq, 1'b1);
        wr(`CAW_ADDR_CONTROL, 8'h00);
        @(posedge pclk);
        check(match_irq, 1'b0);
    endtask

    task automatic t_idle();
        logic [31:0] v;
        wr(`CAW_ADDR_MODE, 8'h80);
        wr(`CAW_ADDR_CONTROL, 8'h40);
        cpu_idle <= 1'b1;
        xfer(1'b0, `CAW_ADDR_COUNT_LOW, 8'h00);
        v = rdata;
        repeat (40) @(posedge pclk);
        rd(`CAW_ADDR_COUNT_LOW, v);
        cpu_idle <= 1'b0;
        repeat (40) @(posedge pclk);
        xfer(1'b0, `CAW_ADDR_COUNT_LOW, 8'h00);
        check(rdata !== v, 1'b1);
    endtask

    // Main sequence; the block has no capture input, and every level that the bench drives on cpu_idle stands
    // for many system clocks, well past the two-cycle minimum for a recognised level.
    initial
    begin
        presetn  = 1'b0;
        req      = '0;
        cpu_idle = 1'b0;
        t_timeout();
        t_defaults();
        t_frozen();
        t_update();
        t_lock();
        t_swtimer();
        t_idle();
        stop_test();
    end
endmodule // tb_caw_watchdog
